/* design/sepe_core.sv */
`timescale 1ns/1ns
`default_nettype none
`include "sepe_defines.svh"

module sepe_core
  import sepe_pkg::*;
#(
  parameter int PROG_CYC = `SEPE_PROG_CYC
) (
  // clock and reset
  input  wire logic                     i_mclk,
  input  wire logic                     i_arst_n,
  // serial link pins
  input  wire logic                     i_select,
  input  wire logic                     i_serial_clock_in,
  input  wire logic                     i_serial_in,
  // serial output pin, three-state
  output logic                          o_serial_out,
  output logic                          o_serial_out_oe,
  // array inspection port
  input  wire logic [`SEPE_ADDR_W-1:0]  i_peek_addr,
  output logic [`SEPE_DATA_W-1:0]       o_peek_data,
  output logic                          o_busy
);

  localparam int FRAME_W = 1 + `SEPE_OP_W + `SEPE_ADDR_W;
  localparam int FULL_W  = FRAME_W + `SEPE_DATA_W;

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  logic [2:0] sync1_r, sync2_r, sync1_nxt, sync2_nxt;
  logic       sk_d_r, cs_d_r;

  always_comb begin
    sync1_nxt = {i_select, i_serial_clock_in, i_serial_in};
    sync2_nxt = sync1_r;
  end

  // first stage read only by the second stage
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      sync1_r <= 3'h0;
      sync2_r <= 3'h0;
      sk_d_r  <= 1'b0;
      cs_d_r  <= 1'b0;
    end else begin
      sync1_r <= sync1_nxt;
      sync2_r <= sync2_nxt;
      sk_d_r  <= sync2_r[1];
      cs_d_r  <= sync2_r[2];
    end
  end

  logic cs, sin, sk_rise, cs_fall, cs_rise;
  assign cs      = sync2_r[2];
  assign sin     = sync2_r[0];
  assign sk_rise = sync2_r[1] & ~sk_d_r;
  assign cs_fall = cs_d_r & ~cs;
  assign cs_rise = cs & ~cs_d_r;

  // ---------------------------------------------------------------
  // instruction receiver
  // ---------------------------------------------------------------
  sepe_rx_t                    rx_r, rx_nxt;
  logic [FULL_W-1:0]           shf_r, shf_nxt;
  logic [5:0]                  cnt_r, cnt_nxt;
  logic                        en_r, en_nxt;
  sepe_op_t                    pend_r, pend_nxt;
  logic                        out_on_r, out_on_nxt;
  logic                        wipe_r, wipe_nxt;
  logic                        busy_r;
  logic                        go;

  logic [`SEPE_ADDR_W-1:0] adr;
  assign adr = shf_r[`SEPE_ADDR_W-1:0];

  always_comb begin
    rx_nxt     = rx_r;
    shf_nxt    = shf_r;
    cnt_nxt    = cnt_r;
    en_nxt     = en_r;
    pend_nxt   = pend_r;
    out_on_nxt = out_on_r;
    wipe_nxt   = wipe_r;
    go         = 1'b0;
    // polled status shows on select rise during a cycle
    if (cs_rise && busy_r) out_on_nxt = 1'b1;
    if (!cs) begin
      out_on_nxt = 1'b0;
      if (cs_fall && rx_r == SEPE_DONE && pend_r != SEPE_NOP && !busy_r)
        go = 1'b1;
      rx_nxt   = SEPE_IDLE;
      pend_nxt = SEPE_NOP;
    end else if (sk_rise) begin
      if (out_on_r && sin) out_on_nxt = 1'b0;
      case (rx_r)
        SEPE_IDLE: begin
          // leading zeros are idle clocks; a one is the start bit unless the status output is on
          if (sin && !out_on_r) begin
            rx_nxt  = SEPE_CMD;
            shf_nxt = '0;
            cnt_nxt = 6'(FRAME_W - 1);
          end
        end
        SEPE_CMD: begin
          shf_nxt = {shf_r[FULL_W-2:0], sin};
          cnt_nxt = cnt_r - 6'h1;
          if (cnt_r == 6'h1) begin
            rx_nxt = SEPE_DONE;
            // shift complete: decode on the next-state values
            case (shf_nxt[`SEPE_OP_W+`SEPE_ADDR_W-1:`SEPE_ADDR_W])
              `SEPE_OP_WRITE: begin
                rx_nxt  = SEPE_DATA;
                cnt_nxt = 6'(`SEPE_DATA_W);
              end
              `SEPE_OP_CLEAR: pend_nxt = en_r ? SEPE_CLR : SEPE_NOP;
              `SEPE_OP_EXT: begin
                case (shf_nxt[`SEPE_ADDR_W-1:`SEPE_ADDR_W-2])
                  // enable state is not changed mid-cycle
                  `SEPE_EXT_EN:     en_nxt = busy_r ? en_r : 1'b1;
                  `SEPE_EXT_DIS:    en_nxt = busy_r ? en_r : 1'b0;
                  `SEPE_EXT_CLRALL: begin
                    pend_nxt = en_r ? SEPE_ALL : SEPE_NOP;
                    wipe_nxt = 1'b1;
                  end
                  `SEPE_EXT_FILL: begin
                    rx_nxt   = SEPE_DATA;
                    cnt_nxt  = 6'(`SEPE_DATA_W);
                    wipe_nxt = 1'b0;
                  end
                  default: rx_nxt = SEPE_DONE;
                endcase
              end
              // reads are not served: the rest of the frame is skipped
              default: rx_nxt = SEPE_SKIP;
            endcase
          end
        end
        SEPE_DATA: begin
          shf_nxt = {shf_r[FULL_W-2:0], sin};
          cnt_nxt = cnt_r - 6'h1;
          if (cnt_r == 6'h1) begin
            rx_nxt = SEPE_DONE;
            if (en_r) begin
              // field positions in shf_r have moved up by the data width less one
              if (shf_r[FULL_W-3 -: `SEPE_OP_W] == `SEPE_OP_WRITE)
                pend_nxt = SEPE_WR;
              else
                pend_nxt = SEPE_ALL;
            end
          end
        end
        // extra clocks after a complete frame cancel nothing
        SEPE_DONE: rx_nxt = SEPE_DONE;
        SEPE_SKIP: rx_nxt = SEPE_SKIP;
        default:   rx_nxt = SEPE_IDLE;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // self-timed program engine, runs on i_mclk only
  // ---------------------------------------------------------------
  logic [`SEPE_DATA_W-1:0]  mem [`SEPE_WORDS];
  logic [31:0]              tmr_r, tmr_nxt;
  logic                     busy_nxt;
  sepe_op_t                 job_r, job_nxt;
  logic [`SEPE_ADDR_W-1:0]  jadr_r, jadr_nxt;
  logic [`SEPE_DATA_W-1:0]  jdat_r, jdat_nxt;
  logic                     commit_now;

  always_comb begin
    busy_nxt = busy_r;
    tmr_nxt  = tmr_r;
    job_nxt  = job_r;
    jadr_nxt = jadr_r;
    jdat_nxt = jdat_r;
    if (go) begin
      busy_nxt = 1'b1;
      tmr_nxt  = 32'(PROG_CYC);
      job_nxt  = pend_r;
      jadr_nxt = (pend_r == SEPE_WR) ? shf_r[`SEPE_DATA_W +: `SEPE_ADDR_W] : adr;
      // a flag, not the shifter, tells clear-all from fill-all: fill data
      // bits sit where the clear-all code would be
      jdat_nxt = (pend_r == SEPE_CLR || (pend_r == SEPE_ALL && wipe_r))
                 ? `SEPE_CLEAR_WORD : shf_r[`SEPE_DATA_W-1:0];
    end else if (busy_r) begin
      // counts on i_mclk alone, no link clock needed
      tmr_nxt = tmr_r - 32'h1;
      if (tmr_r == 32'h1) busy_nxt = 1'b0;
    end
  end

  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rx_r     <= SEPE_IDLE;
      shf_r    <= '0;
      cnt_r    <= 6'h0;
      en_r     <= 1'b0;
      pend_r   <= SEPE_NOP;
      out_on_r <= 1'b0;
      wipe_r   <= 1'b0;
      busy_r   <= 1'b0;
      tmr_r    <= 32'h0;
      job_r    <= SEPE_NOP;
      jadr_r   <= '0;
      jdat_r   <= '0;
    end else begin
      rx_r     <= rx_nxt;
      shf_r    <= shf_nxt;
      cnt_r    <= cnt_nxt;
      en_r     <= en_nxt;
      pend_r   <= pend_nxt;
      out_on_r <= out_on_nxt;
      wipe_r   <= wipe_nxt;
      busy_r   <= busy_nxt;
      tmr_r    <= tmr_nxt;
      job_r    <= job_nxt;
      jadr_r   <= jadr_nxt;
      jdat_r   <= jdat_nxt;
    end
  end

  // array commit at the end of the cycle; new word replaces old whole,
  // so no prior clear is ever needed
  assign commit_now = busy_r && tmr_r == 32'h1;
  genvar g;
  for (g = 0; g < `SEPE_WORDS; g++) begin : g_word
    always_ff @(posedge i_mclk) begin
      if (commit_now && (job_r == SEPE_ALL ||
          jadr_r == `SEPE_ADDR_W'(g)))
        mem[g] <= jdat_r;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign o_serial_out    = ~busy_r;
  assign o_serial_out_oe = out_on_r & cs;
  assign o_peek_data     = mem[i_peek_addr];
  assign o_busy          = busy_r;

endmodule : sepe_core
`default_nettype wire

/* inc/sepe_defines.svh */
`ifndef SEPE_DEFINES_SVH
`define SEPE_DEFINES_SVH
// ---------------------------------------------------------------
// instruction format
// ---------------------------------------------------------------
`define SEPE_ADDR_W      6
`define SEPE_DATA_W      16
`define SEPE_WORDS       64
`define SEPE_OP_W        2
`define SEPE_OP_EXT      2'h0
`define SEPE_OP_WRITE    2'h1
`define SEPE_OP_READ     2'h2
`define SEPE_OP_CLEAR    2'h3
`define SEPE_EXT_DIS     2'h0
`define SEPE_EXT_FILL    2'h1
`define SEPE_EXT_CLRALL  2'h2
`define SEPE_EXT_EN      2'h3
`define SEPE_CLEAR_WORD  16'hFFFF
// ---------------------------------------------------------------
// timing
// ---------------------------------------------------------------
`define SEPE_CLK_MHZ     100
`define SEPE_PROG_US     5
`define SEPE_PROG_CYC    (`SEPE_PROG_US * `SEPE_CLK_MHZ)
`endif

/* inc/sepe_pkg.sv */
package sepe_pkg;
  // ---------------------------------------------------------------
  // state of the instruction receiver
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    SEPE_IDLE = 3'b000,
    SEPE_CMD  = 3'b001,
    SEPE_DATA = 3'b010,
    SEPE_DONE = 3'b011,
    SEPE_SKIP = 3'b100
  } sepe_rx_t;

  // ---------------------------------------------------------------
  // self-timed operation kinds
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    SEPE_NOP  = 2'b00,
    SEPE_WR   = 2'b01,
    SEPE_CLR  = 2'b10,
    SEPE_ALL  = 2'b11
  } sepe_op_t;
endpackage : sepe_pkg

/* bench/sepe_core_asserts.sv */
`timescale 1ns/1ns
`default_nettype none
// ---------------------------------------------------------------
// pin timing checks
// ---------------------------------------------------------------
module sepe_core_asserts #(
  parameter int PROG_CYC = 500
) (
  input wire logic i_mclk,
  input wire logic i_arst_n,
  input wire logic i_select,
  input wire logic i_serial_clock_in,
  input wire logic i_serial_in,
  input wire logic o_serial_out,
  input wire logic o_serial_out_oe,
  input wire logic o_busy
);
  int busy_cnt_r;

  // busy length counter, cleared while idle
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n)
      busy_cnt_r <= 0;
    else
      busy_cnt_r <= o_busy ? busy_cnt_r + 1 : 0;
  end

  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_arst_n);

  sequence s_start;
    $rose(o_busy);
  endsequence
  sequence s_dummy;
    i_select && o_serial_out_oe && i_serial_in && $rose(i_serial_clock_in);
  endsequence

  a_busy_length: assert property ($fell(o_busy) |-> busy_cnt_r == PROG_CYC)
    else $error("busy length wrong");
  a_status_busy: assert property (o_serial_out_oe && o_busy |-> !o_serial_out)
    else $error("status not low while busy");
  a_status_ready: assert property (o_serial_out_oe && !o_busy |-> o_serial_out)
    else $error("status not high when ready");
  a_start_after: assert property (s_start |-> !i_select && !$past(i_select, 2))
    else $error("cycle started before select fell");
  a_start_prompt: assert property (s_start |-> $past(i_select, 5))
    else $error("cycle started late");
  a_oe_deselect: assert property (!i_select [*4] |-> !o_serial_out_oe)
    else $error("output driven while deselected");
  a_oe_rise_sel: assert property ($rose(o_serial_out_oe) |-> i_select)
    else $error("output enabled without select");
  a_dummy_float: assert property (s_dummy |-> ##[1:6] !o_serial_out_oe)
    else $error("output kept after dummy one");
endmodule : sepe_core_asserts
`default_nettype wire

/* bench/sepe_host.sv */
`timescale 1ns/1ns
`default_nettype none
// ---------------------------------------------------------------
// host side of the serial link
// ---------------------------------------------------------------
module sepe_host (
  input  wire logic i_mclk,
  output logic      o_select,
  output logic      o_serial_clock_in,
  output logic      o_serial_in
);
  // link idles with clock still and select low
  initial begin
    o_select = 1'b0;
    o_serial_clock_in = 1'b0;
    o_serial_in = 1'b0;
  end

  // half of an 80 ns link clock period
  task automatic half();
    repeat (4) @(negedge i_mclk);
  endtask : half

  // data settles a half period before the rise
  task automatic bit_out(input logic b);
    o_serial_in = b;
    half();
    o_serial_clock_in = 1'b1;
    half();
    o_serial_clock_in = 1'b0;
  endtask : bit_out

  task automatic set_sel(input logic s);
    o_select = s;
    o_serial_in = ~o_serial_in; // released line must not keep its level
  endtask : set_sel

  // whole frame, msb first, then deselect to launch it
  task automatic frame(input logic [31:0] bits, input int n);
    set_sel(1'b1);
    half();
    for (int i = n - 1; i >= 0; i--) bit_out(bits[i]);
    set_sel(1'b0);
  endtask : frame
endmodule : sepe_host
`default_nettype wire

/* bench/sepe_core_tb.sv */
`timescale 1ns/1ns
`default_nettype none
`include "sepe_defines.svh"
// ---------------------------------------------------------------
// directed scenarios
// ---------------------------------------------------------------
module sepe_core_tb;
  localparam int PROG = 400; // long enough to send a frame inside a cycle
  logic        i_mclk, i_arst_n, sel, sck, sdi, sout, soe, busy;
  logic [5:0]  paddr;
  logic [15:0] pdata;
  int          failures, total_checks;

  sepe_core #(.PROG_CYC(PROG)) uut (.i_mclk(i_mclk), .i_arst_n(i_arst_n), .i_select(sel),
    .i_serial_clock_in(sck), .i_serial_in(sdi), .o_serial_out(sout),
    .o_serial_out_oe(soe), .i_peek_addr(paddr), .o_peek_data(pdata), .o_busy(busy));
  sepe_host host (.i_mclk(i_mclk), .o_select(sel), .o_serial_clock_in(sck), .o_serial_in(sdi));

  // 100 MHz system clock
  initial begin
    i_mclk = 1'b0;
    forever #5 i_mclk = ~i_mclk;
  end

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic final_report();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : final_report

  task automatic peek(input logic [5:0] a, input logic [15:0] e);
    @(negedge i_mclk);
    paddr = a;
    #1;
    chk(pdata, e);
  endtask : peek

  task automatic wait_idle();
    for (int i = 0; i < PROG + 50 && busy !== 1'b0; i++) @(negedge i_mclk);
    repeat (4) @(negedge i_mclk);
  endtask : wait_idle

  // frame, then count busy cycles from the select fall
  task automatic op(input logic [31:0] bits, input int n, input logic go);
    logic [15:0] c;
    c = 16'h0;
    host.frame(bits, n);
    for (int i = 0; i < PROG + 20; i++) begin
      @(negedge i_mclk);
      c = c + 16'(busy);
    end
    chk(c, go ? 16'(PROG) : 16'h0);
  endtask : op

  task automatic t_power_up();
    op({1'b1, `SEPE_OP_WRITE, 6'h03, 16'h5A5A}, 25, 1'b0);
    op({1'b1, `SEPE_OP_EXT, `SEPE_EXT_EN, 4'h0}, 9, 1'b0);
    op({1'b1, `SEPE_OP_EXT, `SEPE_EXT_FILL, 4'h0, 16'h1234}, 25, 1'b1);
    for (int a = 0; a < 64; a++) peek(a[5:0], 16'h1234);
  endtask : t_power_up

  task automatic t_write_poll();
    host.frame({1'b1, `SEPE_OP_WRITE, 6'h05, 16'hA5C3}, 25);
    repeat (30) @(negedge i_mclk);
    host.set_sel(1'b1);
    repeat (8) @(negedge i_mclk);
    chk(soe, 1'b1);
    chk(sout, 1'b0);
    wait_idle();
    chk(sout, 1'b1);
    host.bit_out(1'b1);
    repeat (4) @(negedge i_mclk);
    chk(soe, 1'b0);
    host.set_sel(1'b0);
    repeat (8) @(negedge i_mclk);
    peek(6'h05, 16'hA5C3);
    peek(6'h04, 16'h1234);
  endtask : t_write_poll

  // a write sent while a clear runs must be dropped
  task automatic t_clear_busy();
    host.frame({1'b1, `SEPE_OP_CLEAR, 6'h05}, 9);
    repeat (8) @(negedge i_mclk);
    // select during busy arms the status; a dummy one first frees the start bit
    host.frame({1'b1, 1'b1, `SEPE_OP_WRITE, 6'h06, 16'h0F0F}, 26);
    wait_idle();
    repeat (10) @(negedge i_mclk);
    chk(busy, 1'b0);
    peek(6'h05, `SEPE_CLEAR_WORD);
    peek(6'h06, 16'h1234);
  endtask : t_clear_busy

  task automatic t_clear_all();
    op({1'b1, `SEPE_OP_EXT, `SEPE_EXT_CLRALL, 4'h0}, 9, 1'b1);
    for (int a = 0; a < 64; a++) peek(a[5:0], `SEPE_CLEAR_WORD);
    op({1'b1, `SEPE_OP_READ, 6'h02}, 9, 1'b0);
    peek(6'h02, `SEPE_CLEAR_WORD);
    op({1'b1, `SEPE_OP_EXT, `SEPE_EXT_DIS, 4'h0}, 9, 1'b0);
    op({1'b1, `SEPE_OP_WRITE, 6'h01, 16'h0000}, 25, 1'b0);
    peek(6'h01, `SEPE_CLEAR_WORD);
  endtask : t_clear_all

  // main sequence
  initial begin
    i_arst_n = 1'b0;
    paddr = 6'h00;
    failures = 0;
    total_checks = 0;
    repeat (2) @(negedge i_mclk);
    i_arst_n = 1'b1;
    t_power_up();
    t_write_poll();
    t_clear_busy();
    t_clear_all();
    final_report();
  end

  // watchdog, well beyond the expected run
  initial begin
    #500000;
    failures++;
    final_report();
  end
endmodule : sepe_core_tb

bind sepe_core sepe_core_asserts #(.PROG_CYC(PROG_CYC)) u_asserts (.i_mclk(i_mclk),
  .i_arst_n(i_arst_n), .i_select(i_select), .i_serial_clock_in(i_serial_clock_in),
  .i_serial_in(i_serial_in), .o_serial_out(o_serial_out),
  .o_serial_out_oe(o_serial_out_oe), .o_busy(o_busy));
`default_nettype wire
